/* File: irq_source_model.sv */
// Interrupt source model: controller request level, line requests, straps.
module irq_source_model #(
	parameter logic [2:0] TIMER_LINE = 3'h5,
	parameter logic [2:0] PERF_LINE  = 3'h6,
	parameter logic [2:0] DEBUG_LINE = 3'h2
) (
	input  wire logic       core_clk,
	input  wire logic [7:0] level_cmd,
	input  wire logic [7:0] line_cmd,
	output logic      [7:0] eic_req_level,
	output logic      [7:0] hw_irq_pending,
	output logic      [2:0] timer_line_strap,
	output logic      [2:0] perf_line_strap,
	output logic      [2:0] debug_line_strap
);
	logic [7:0] level_q;
	logic [7:0] line_q;

	// Straps stay fixed for the whole run.
	assign timer_line_strap = TIMER_LINE;
	assign perf_line_strap  = PERF_LINE;
	assign debug_line_strap = DEBUG_LINE;

	initial begin
		level_q        = 8'h00;
		line_q         = 8'h00;
		eic_req_level  = 8'h00;
		hw_irq_pending = 8'h00;
	end

	// Requests answer one cycle late and change after the falling edge.
	always @(posedge core_clk) begin
		level_q <= level_cmd;
		line_q  <= line_cmd;
	end

	always @(negedge core_clk) begin
		eic_req_level  <= level_q;
		hw_irq_pending <= line_q;
	end
endmodule : irq_source_model

/* File: status_cfg.svh */
// Bit positions, reset values and field constants for the status logic.
`ifndef STATUS_CFG_SVH
`define STATUS_CFG_SVH
`define ST_RP        27
`define ST_FR        26
`define ST_RE        25
`define ST_MX        24
`define ST_BEV       22
`define ST_TS        21
`define ST_SR        20
`define ST_NMI       19
`define ST_IM9       18
`define ST_CEE       17
`define ST_IM_HI     16
`define ST_IM_LO     10
`define ST_SW_HI     9
`define ST_SW_LO     8
`define ST_UM        4
`define ST_ERL       2
`define ST_EXL       1
`define ST_IE        0
`define IC_TIMER_HI  31
`define IC_TIMER_LO  29
`define IC_PERF_HI   28
`define IC_PERF_LO   26
`define IC_DBG_HI    25
`define IC_DBG_LO    23
`define IC_PF        22
`define IC_ICE       21
`define IC_STK_HI    20
`define IC_STK_LO    16
`define IC_CLR       15
`define IC_APE       14
`define RST_BEV      1'h1
`define RST_ERL      1'h1
`define RST_PROLOGUE_STACK_DROP   5'h03
`define STK_MIN_WORDS 5'h03
`define STRAP_RST    3'h0
`endif

/* File: status_interrupt_control.sv */
// Operating-mode status and extended interrupt control registers.
`include "status_cfg.svh"
module status_interrupt_control #(
	parameter bit FPU_PRESENT = 1'b1,
	parameter bit UDI_PRESENT = 1'b1,
	parameter bit DBG_PRESENT = 1'b1
) (
	input  wire logic                core_clk,
	input  wire logic                resetn,
	input  wire status_pkg::cop_req_s cop_req,
	output logic [31:0]              cop_rdata,
	output logic                     cop_rvalid,
	input  wire status_pkg::cpu_evt_s cpu_evt,
	input  wire logic                ext_ctrl_mode_flag,
	input  wire logic                debug_mode,
	input  wire logic [7:0]          hw_irq_pending,
	input  wire logic [1:0]          sw_irq_pending,
	input  wire logic [7:0]          eic_req_level,
	input  wire logic [2:0]          timer_line_strap,
	input  wire logic [2:0]          perf_line_strap,
	input  wire logic [2:0]          debug_line_strap,
	output logic                     kernel_mode,
	output logic                     user_byte_order_flip,
	output logic                     fpu_wide_reg_sel,
	output logic                     boot_vector_sel,
	output logic                     use_error_return_pc,
	output logic                     exc_state_hold,
	output logic                     irq_take,
	output logic                     machine_check,
	output logic                     dsp_fault,
	output logic                     udi_fault,
	output logic [4:0]               prologue_stack_drop
);
	logic       rst_a_q;
	logic       rst_n_q;
	logic [8:0] strap_lv;
	logic       rp_q, fr_q, re_q, mx_q, bev_q, ts_q, sr_q, nmi_q, cee_q;
	logic [7:0] hw_irq_line_masks_q;
	logic [1:0] sw_irq_line_masks_q;
	logic       um_q, erl_q, exl_q, ie_q;
	logic       pf_q, ice_q, clr_q, ape_q;
	logic [4:0] prologue_stack_drop_q;
	logic [31:0] rdata_q;
	logic       rvalid_q;
	logic       kernel_q, flip_q, boot_q, errpc_q, hold_q;
	logic       irq_q, mchk_q, dsp_q, udi_q;
	logic [4:0] drop_q;
	logic       wr_st, wr_ic, reset_class, do_clear, gate, want;
	logic [31:0] status_word, interrupt_control_ext_word;
	logic [7:0] current_priority_level;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rst_a_q <= 1'h0;
			rst_n_q <= 1'h0;
		end else begin
			rst_a_q <= 1'h1;
			rst_n_q <= rst_a_q;
		end
	end

	strap_sync #(.W(9)) u_strap (
		.clk   (core_clk),
		.rst_n (rst_n_q),
		.pin   ({timer_line_strap, perf_line_strap, debug_line_strap}),
		.level (strap_lv)
	);

	assign wr_st = cop_req.valid && cop_req.write
		&& cop_req.sel == status_pkg::SEL_STATUS;
	assign wr_ic = cop_req.valid && cop_req.write
		&& cop_req.sel == status_pkg::SEL_INTERRUPT_CONTROL_EXT;
	assign reset_class = cpu_evt.cache_err || cpu_evt.nmi_entry
		|| cpu_evt.soft_entry;
	assign do_clear = cpu_evt.level_clear && clr_q;
	assign current_priority_level = hw_irq_line_masks_q;

	// Plain read/write status controls.
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rp_q <= 1'h0;
			fr_q <= 1'h0;
			re_q <= 1'h0;
			mx_q <= 1'h0;
			bev_q <= `RST_BEV;
			cee_q <= 1'h0;
			hw_irq_line_masks_q <= 8'h00;
			sw_irq_line_masks_q <= 2'h0;
		end else if (wr_st) begin
			rp_q <= cop_req.wdata[`ST_RP];
			fr_q <= FPU_PRESENT && cop_req.wdata[`ST_FR];
			re_q <= cop_req.wdata[`ST_RE];
			mx_q <= cop_req.wdata[`ST_MX];
			bev_q <= cop_req.wdata[`ST_BEV];
			cee_q <= cop_req.wdata[`ST_CEE];
			hw_irq_line_masks_q <= {cop_req.wdata[`ST_IM9],
				cop_req.wdata[`ST_IM_HI:`ST_IM_LO]};
			sw_irq_line_masks_q <= cop_req.wdata[`ST_SW_HI:`ST_SW_LO];
		end
	end

	// Sticky hardware flags: the hardware set wins over a software clear.
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ts_q <= 1'h0;
			sr_q <= 1'h0;
			nmi_q <= 1'h0;
		end else begin
			if (cpu_evt.tlb_multi_hit) begin
				ts_q <= 1'h1;
			end else if (wr_st && !cop_req.wdata[`ST_TS]) begin
				ts_q <= 1'h0;
			end
			if (cpu_evt.soft_entry) begin
				sr_q <= 1'h1;
			end else if (cpu_evt.nmi_entry) begin
				sr_q <= 1'h0;
			end else if (wr_st && !cop_req.wdata[`ST_SR]) begin
				sr_q <= 1'h0;
			end
			if (cpu_evt.nmi_entry && !cpu_evt.soft_entry) begin
				nmi_q <= 1'h1;
			end else if (cpu_evt.soft_entry) begin
				nmi_q <= 1'h0;
			end else if (wr_st && !cop_req.wdata[`ST_NMI]) begin
				nmi_q <= 1'h0;
			end
		end
	end

	// Privilege and level bits.
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			erl_q <= `RST_ERL;
			exl_q <= 1'h0;
			um_q <= 1'h0;
		end else begin
			if (reset_class) begin
				erl_q <= 1'h1;
			end else if (do_clear) begin
				erl_q <= 1'h0;
			end else if (wr_st) begin
				erl_q <= cop_req.wdata[`ST_ERL];
			end
			if (cpu_evt.exc_take && !reset_class) begin
				exl_q <= 1'h1;
			end else if (do_clear) begin
				exl_q <= 1'h0;
			end else if (wr_st) begin
				exl_q <= cop_req.wdata[`ST_EXL];
			end
			if (do_clear) begin
				um_q <= 1'h0;
			end else if (wr_st) begin
				um_q <= cop_req.wdata[`ST_UM];
			end
		end
	end

	// Master interrupt enable.
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ie_q <= 1'h0;
		end else if (cpu_evt.irq_off_instr) begin
			ie_q <= 1'h0;
		end else if (cpu_evt.irq_on_instr) begin
			ie_q <= 1'h1;
		end else if (wr_st) begin
			ie_q <= cop_req.wdata[`ST_IE];
		end
	end

	// Writable interrupt-control fields; routing fields take no write.
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pf_q <= 1'h0;
			ice_q <= 1'h0;
			clr_q <= 1'h0;
			ape_q <= 1'h0;
			prologue_stack_drop_q <= `RST_PROLOGUE_STACK_DROP;
		end else if (wr_ic) begin
			pf_q <= cop_req.wdata[`IC_PF];
			ice_q <= cop_req.wdata[`IC_ICE];
			clr_q <= cop_req.wdata[`IC_CLR];
			ape_q <= cop_req.wdata[`IC_APE];
			prologue_stack_drop_q <= cop_req.wdata[`IC_STK_HI:`IC_STK_LO];
		end
	end

	always_comb begin
		status_word = 32'h00000000;
		status_word[`ST_RP] = rp_q;
		status_word[`ST_FR] = FPU_PRESENT && fr_q;
		status_word[`ST_RE] = re_q;
		status_word[`ST_MX] = mx_q;
		status_word[`ST_BEV] = bev_q;
		status_word[`ST_TS] = ts_q;
		status_word[`ST_SR] = sr_q;
		status_word[`ST_NMI] = nmi_q;
		status_word[`ST_IM9] = hw_irq_line_masks_q[7];
		status_word[`ST_CEE] = cee_q;
		status_word[`ST_IM_HI:`ST_IM_LO] = hw_irq_line_masks_q[6:0];
		status_word[`ST_SW_HI:`ST_SW_LO] = sw_irq_line_masks_q;
		status_word[`ST_UM] = um_q;
		status_word[`ST_ERL] = erl_q;
		status_word[`ST_EXL] = exl_q;
		status_word[`ST_IE] = ie_q;
		interrupt_control_ext_word = 32'h00000000;
		interrupt_control_ext_word[`IC_TIMER_HI:`IC_TIMER_LO] = strap_lv[8:6];
		interrupt_control_ext_word[`IC_PERF_HI:`IC_PERF_LO] = strap_lv[5:3];
		interrupt_control_ext_word[`IC_DBG_HI:`IC_DBG_LO] = DBG_PRESENT ? strap_lv[2:0]
			: `STRAP_RST;
		interrupt_control_ext_word[`IC_PF] = pf_q;
		interrupt_control_ext_word[`IC_ICE] = ice_q;
		interrupt_control_ext_word[`IC_STK_HI:`IC_STK_LO] = prologue_stack_drop_q;
		interrupt_control_ext_word[`IC_CLR] = clr_q;
		interrupt_control_ext_word[`IC_APE] = ape_q;
	end

	// Register read port: data one cycle after the request.
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rdata_q <= 32'h00000000;
			rvalid_q <= 1'h0;
		end else begin
			rvalid_q <= cop_req.valid && !cop_req.write;
			if (cop_req.valid && !cop_req.write) begin
				rdata_q <= (cop_req.sel == status_pkg::SEL_STATUS)
					? status_word : interrupt_control_ext_word;
			end
		end
	end

	assign gate = ie_q && !exl_q && !erl_q && !debug_mode;
	assign want = ext_ctrl_mode_flag ? (eic_req_level > current_priority_level)
		: (|(hw_irq_pending & hw_irq_line_masks_q)
		|| |(sw_irq_pending & sw_irq_line_masks_q));

	// Derived mode and fault outputs.
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			kernel_q <= 1'h1;
			flip_q <= 1'h0;
			boot_q <= `RST_BEV;
			errpc_q <= `RST_ERL;
			hold_q <= 1'h0;
			irq_q <= 1'h0;
			mchk_q <= 1'h0;
			dsp_q <= 1'h0;
			udi_q <= 1'h0;
			drop_q <= `STK_MIN_WORDS;
		end else begin
			kernel_q <= !um_q || exl_q || erl_q;
			flip_q <= re_q && um_q && !exl_q && !erl_q
				&& !debug_mode;
			boot_q <= bev_q;
			errpc_q <= erl_q;
			hold_q <= exl_q;
			irq_q <= gate && want;
			mchk_q <= cpu_evt.tlb_multi_hit;
			dsp_q <= cpu_evt.dsp_instr && !mx_q;
			udi_q <= UDI_PRESENT && cpu_evt.udi_instr && !cee_q;
			drop_q <= (prologue_stack_drop_q < `STK_MIN_WORDS) ? `STK_MIN_WORDS
				: prologue_stack_drop_q;
		end
	end

	assign cop_rdata = rdata_q;
	assign cop_rvalid = rvalid_q;
	assign kernel_mode = kernel_q;
	assign user_byte_order_flip = flip_q;
	assign fpu_wide_reg_sel = fr_q;
	assign boot_vector_sel = boot_q;
	assign use_error_return_pc = errpc_q;
	assign exc_state_hold = hold_q;
	assign irq_take = irq_q;
	assign machine_check = mchk_q;
	assign dsp_fault = dsp_q;
	assign udi_fault = udi_q;
	assign prologue_stack_drop = drop_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n_q);

	sequence err_entry_s;
		cpu_evt.cache_err || cpu_evt.nmi_entry || cpu_evt.soft_entry;
	endsequence
	sequence err_seen_s;
		##1 erl_q ##1 kernel_mode && use_error_return_pc && !irq_take;
	endsequence

	ts_set_a: assert property (cpu_evt.tlb_multi_hit
		|=> ts_q && machine_check)
		else $error("Multi-hit flag or machine check missing.");
	ts_noset_a: assert property (!ts_q && !cpu_evt.tlb_multi_hit
		|=> !ts_q)
		else $error("Multi-hit flag set without a hit.");
	nmi_cause_a: assert property (cpu_evt.nmi_entry && !cpu_evt.soft_entry
		|=> nmi_q && !sr_q)
		else $error("Entry cause flags wrong after NMI.");
	err_entry_a: assert property (err_entry_s |-> err_seen_s)
		else $error("Error level entry not reflected.");
	irq_block_a: assert property (!gate |=> !irq_take)
		else $error("Interrupt taken while blocked.");
	eic_level_a: assert property (ext_ctrl_mode_flag && eic_req_level <= current_priority_level
		|=> !irq_take)
		else $error("Interrupt at or below current level.");
	dsp_fault_a: assert property (cpu_evt.dsp_instr && !mx_q
		|=> dsp_fault)
		else $error("Signal-processing fault missing.");
	resv_zero_a: assert property (cop_rvalid |-> cop_rdata[23] == 1'b0
		|| $past(cop_req.sel) == status_pkg::SEL_INTERRUPT_CONTROL_EXT)
		else $error("Reserved status bit read nonzero.");
	level_clr_a: assert property (do_clear && !reset_class
		|=> !exl_q && !erl_q && !um_q)
		else $error("Level clear on prologue failed.");
	stk_drop_a: assert property (prologue_stack_drop_q <= 5'h03 |=> prologue_stack_drop
		== 5'h03)
		else $error("Small stack drop code not three words.");
endmodule : status_interrupt_control

/* File: status_pkg.sv */
// Types shared by the status and interrupt control logic.
package status_pkg;
	typedef enum logic [0:0] {
		SEL_STATUS = 1'h0,
		SEL_INTERRUPT_CONTROL_EXT = 1'h1
	} reg_sel_e;

	typedef struct packed {
		logic        valid;
		logic        write;
		reg_sel_e    sel;
		logic [31:0] wdata;
	} cop_req_s;

	typedef struct packed {
		logic exc_take;
		logic cache_err;
		logic nmi_entry;
		logic soft_entry;
		logic tlb_multi_hit;
		logic irq_off_instr;
		logic irq_on_instr;
		logic level_clear;
		logic dsp_instr;
		logic udi_instr;
	} cpu_evt_s;
endpackage : status_pkg

/* File: strap_sync.sv */
// Three-stage pin synchroniser; a change counts once stages two and three agree.
`include "status_cfg.svh"
module strap_sync #(
	parameter int W = 9
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] level
);
	genvar i;
	for (i = 0; i < W; i++) begin : g_bit
		logic s1_q;
		logic s2_q;
		logic s3_q;
		logic lv_q;
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				s1_q <= 1'h0;
				s2_q <= 1'h0;
				s3_q <= 1'h0;
				lv_q <= 1'h0;
			end else begin
				s1_q <= pin[i];
				s2_q <= s1_q;
				s3_q <= s2_q;
				if (s2_q == s3_q) begin
					lv_q <= s3_q;
				end
			end
		end
		assign level[i] = lv_q;
	end
endmodule : strap_sync

/* File: testbench.sv */
// Self-checking bench for the status and interrupt control block.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [2:0] TL = 3'h5;
	localparam logic [2:0] PL = 3'h6;
	localparam logic [2:0] DL = 3'h2;
	localparam status_pkg::reg_sel_e S = status_pkg::SEL_STATUS;
	localparam status_pkg::reg_sel_e I = status_pkg::SEL_INTERRUPT_CONTROL_EXT;
	localparam logic [9:0] E_EXC  = 10'h200;
	localparam logic [9:0] E_CERR = 10'h100;
	localparam logic [9:0] E_NMI  = 10'h080;
	localparam logic [9:0] E_SOFT = 10'h040;
	localparam logic [9:0] E_TLB  = 10'h020;
	localparam logic [9:0] E_OFF  = 10'h010;
	localparam logic [9:0] E_ON   = 10'h008;
	localparam logic [9:0] E_CLR  = 10'h004;
	localparam logic [9:0] E_DSP  = 10'h002;
	localparam logic [9:0] E_UDI  = 10'h001;
	localparam logic [31:0] ST = {TL, PL, DL, 23'h000000};

	logic                  core_clk, resetn, cop_rvalid;
	logic                  ext_ctrl_mode_flag, debug_mode;
	logic                  kernel_mode, user_byte_order_flip;
	logic                  fpu_wide_reg_sel, boot_vector_sel;
	logic                  use_error_return_pc, exc_state_hold;
	logic                  irq_take, machine_check, dsp_fault, udi_fault;
	logic [31:0]           cop_rdata, rd_q, sm, w, r;
	logic [7:0]            hw_irq_pending, eic_req_level;
	logic [7:0]            level_cmd, line_cmd;
	logic [1:0]            sw_irq_pending;
	logic [2:0]            timer_line_strap, perf_line_strap;
	logic [2:0]            debug_line_strap;
	logic [4:0]            prologue_stack_drop;
	status_pkg::cop_req_s  cop_req;
	status_pkg::cpu_evt_s  cpu_evt;
	int                    miscompares, tests_run, seed, i, n0, n1;
	int                    rv_n, mc_n, dsp_n, udi_n;

	status_interrupt_control DUT (.core_clk(core_clk), .resetn(resetn),
		.cop_req(cop_req), .cop_rdata(cop_rdata), .cop_rvalid(cop_rvalid),
		.cpu_evt(cpu_evt), .ext_ctrl_mode_flag(ext_ctrl_mode_flag),
		.debug_mode(debug_mode), .hw_irq_pending(hw_irq_pending),
		.sw_irq_pending(sw_irq_pending), .eic_req_level(eic_req_level),
		.timer_line_strap(timer_line_strap),
		.perf_line_strap(perf_line_strap),
		.debug_line_strap(debug_line_strap), .kernel_mode(kernel_mode),
		.user_byte_order_flip(user_byte_order_flip),
		.fpu_wide_reg_sel(fpu_wide_reg_sel),
		.boot_vector_sel(boot_vector_sel),
		.use_error_return_pc(use_error_return_pc),
		.exc_state_hold(exc_state_hold), .irq_take(irq_take),
		.machine_check(machine_check), .dsp_fault(dsp_fault),
		.udi_fault(udi_fault), .prologue_stack_drop(prologue_stack_drop));

	irq_source_model #(.TIMER_LINE(TL), .PERF_LINE(PL), .DEBUG_LINE(DL)) src (
		.core_clk(core_clk), .level_cmd(level_cmd), .line_cmd(line_cmd),
		.eic_req_level(eic_req_level), .hw_irq_pending(hw_irq_pending),
		.timer_line_strap(timer_line_strap),
		.perf_line_strap(perf_line_strap),
		.debug_line_strap(debug_line_strap));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// Counts one-cycle pulses and captures read data.
	always @(negedge core_clk) begin
		if (cop_rvalid === 1'b1) begin
			rv_n++;
			rd_q = cop_rdata;
		end
		if (machine_check === 1'b1) mc_n++;
		if (dsp_fault === 1'b1) dsp_n++;
		if (udi_fault === 1'b1) udi_n++;
	end

	function automatic logic [31:0] exp_st(input logic [31:0] p, w);
		return (w & 32'h0F47_FF17) | (p & w & 32'h0038_0000);
	endfunction : exp_st

	function automatic logic exp_irq(input logic [31:0] s);
		logic [7:0] lvl;
		lvl = {s[18], s[16:10]};
		if (!s[0] || s[1] || s[2] || debug_mode) return 1'b0;
		if (ext_ctrl_mode_flag) return level_cmd > lvl;
		return |(line_cmd & lvl) || |(sw_irq_pending & s[9:8]);
	endfunction : exp_irq

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input status_pkg::reg_sel_e s, input logic [31:0] d);
		@(negedge core_clk);
		cop_req = '{1'b1, 1'b1, s, d};
		@(negedge core_clk);
		cop_req.valid = 1'b0;
		repeat (3) @(negedge core_clk);
	endtask : wr

	task automatic rd_chk(input status_pkg::reg_sel_e s, input logic [31:0] e);
		int n;
		n = rv_n;
		@(negedge core_clk);
		cop_req = '{1'b1, 1'b0, s, 32'h0000_0000};
		@(negedge core_clk);
		cop_req.valid = 1'b0;
		repeat (3) @(negedge core_clk);
		check(rv_n - n, 1);
		check(s == S ? rd_q & 32'h0FFF_FFFF : rd_q, e);
	endtask : rd_chk

	task automatic pulse(input logic [9:0] e);
		@(negedge core_clk);
		cpu_evt = e;
		@(negedge core_clk);
		cpu_evt = '0;
		repeat (3) @(negedge core_clk);
	endtask : pulse

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : final_report

	initial begin
		#200000;
		miscompares++;
		final_report;
	end

	initial begin
		{miscompares, tests_run, rv_n, mc_n, dsp_n, udi_n} = '0;
		seed = 44;
		resetn = 1'b0;
		cop_req = '0;
		cpu_evt = '0;
		{ext_ctrl_mode_flag, debug_mode, sw_irq_pending} = '0;
		{level_cmd, line_cmd, rd_q} = '0;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		resetn = 1'b1;
		repeat (12) @(negedge core_clk);
		check(kernel_mode, 1);
		check(boot_vector_sel, 1);
		check(use_error_return_pc, 1);
		rd_chk(S, 32'h0040_0004);
		rd_chk(I, ST | 32'h0003_0000);
		wr(I, 32'hFFFF_FFFF);
		rd_chk(I, ST | 32'h007F_C000);
		for (i = 0; i < 9; i++) begin
			wr(I, i < 8 ? i << 16 : 32'h001F_0000);
			check(prologue_stack_drop, i < 4 ? 3 : i < 8 ? i : 31);
		end
		sm = 32'h0040_0004;
		repeat (30) begin
			w = $random(seed);
			r = $random(seed);
			w[2:0] = {w[2:1] & {2{r[26]}}, 1'b1};
			ext_ctrl_mode_flag = r[31];
			debug_mode = r[30] & r[29];
			line_cmd = r[7:0];
			sw_irq_pending = r[9:8];
			level_cmd = r[28] ? {w[18], w[16:10]} : r[27:20];
			wr(S, w);
			sm = exp_st(sm, w);
			rd_chk(S, sm);
			check(irq_take, exp_irq(sm));
		end
		{ext_ctrl_mode_flag, debug_mode} = '0;
		for (i = 0; i < 3; i++) begin
			wr(S, 32'h0000_0000);
			rd_chk(S, 32'h0000_0000);
			pulse(i == 0 ? E_SOFT : i == 1 ? E_NMI : E_CERR);
			sm = i == 0 ? 32'h0010_0004 : i == 1 ? 32'h0008_0004 : 32'h4;
			rd_chk(S, sm);
			check(use_error_return_pc, 1);
		end
		n0 = mc_n;
		pulse(E_TLB);
		check(mc_n - n0, 1);
		rd_chk(S, 32'h0020_0004);
		wr(S, 32'h0000_0000);
		rd_chk(S, 32'h0000_0000);
		wr(S, 32'h0600_0010);
		check(kernel_mode, 0);
		check(user_byte_order_flip, 1);
		check(fpu_wide_reg_sel, 1);
		check(boot_vector_sel, 0);
		debug_mode = 1'b1;
		repeat (3) @(negedge core_clk);
		check(user_byte_order_flip, 0);
		debug_mode = 1'b0;
		pulse(E_EXC);
		check(kernel_mode, 1);
		check(exc_state_hold, 1);
		wr(I, 32'h0000_8000);
		pulse(E_CLR);
		rd_chk(S, 32'h0600_0000);
		wr(S, 32'h0000_0016);
		wr(I, 32'h0000_0000);
		pulse(E_CLR);
		rd_chk(S, 32'h0000_0016);
		line_cmd = 8'h01;
		wr(S, 32'h0000_0401);
		check(irq_take, 1);
		pulse(E_OFF);
		check(irq_take, 0);
		pulse(E_ON);
		check(irq_take, 1);
		debug_mode = 1'b1;
		repeat (3) @(negedge core_clk);
		check(irq_take, 0);
		debug_mode = 1'b0;
		pulse(E_EXC);
		check(irq_take, 0);
		for (i = 0; i < 2; i++) begin
			wr(S, i ? 32'h0102_0000 : 32'h0000_0000);
			n0 = dsp_n;
			n1 = udi_n;
			pulse(E_DSP | E_UDI);
			check(dsp_n - n0, 1 - i);
			check(udi_n - n1, 1 - i);
		end
		final_report;
	end
endmodule : testbench
